// ---- hw/dti_pkg.sv ----
package dti_pkg;

	// ----------------------------------------------------------------
	// widths and register file
	// ----------------------------------------------------------------
	localparam int XLEN = 32;
	localparam int REG_CNT = 16;
	localparam logic [3:0] REG_ZERO = 4'h0;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

	// ----------------------------------------------------------------
	// instruction field positions
	// ----------------------------------------------------------------
	localparam int FLD_OP_MSB = 15;
	localparam int FLD_OP_LSB = 12;
	localparam int FLD_N_MSB = 11;
	localparam int FLD_N_LSB = 8;
	localparam int FLD_M_MSB = 7;
	localparam int FLD_M_LSB = 4;
	localparam int FLD_S_MSB = 3;
	localparam int FLD_S_LSB = 0;
	localparam int FLD_I_MSB = 7;

	// ----------------------------------------------------------------
	// major opcodes and sub-codes
	// ----------------------------------------------------------------
	localparam logic [3:0] OP_MOVI = 4'he;
	localparam logic [3:0] OP_LDW_PC = 4'h9;
	localparam logic [3:0] OP_LDL_PC = 4'hd;
	localparam logic [3:0] OP_GRP6 = 4'h6;
	localparam logic [3:0] OP_GRP2 = 4'h2;
	localparam logic [3:0] OP_STL_D = 4'h1;
	localparam logic [3:0] OP_LDL_D = 4'h5;
	localparam logic [3:0] OP_GRP8 = 4'h8;
	localparam logic [3:0] OP_GRP0 = 4'h0;
	localparam logic [3:0] G6_LDB = 4'h0;
	localparam logic [3:0] G6_LDL = 4'h2;
	localparam logic [3:0] G6_MOV = 4'h3;
	localparam logic [3:0] G6_PIB = 4'h4;
	localparam logic [3:0] G6_PIL = 4'h6;
	localparam logic [3:0] G2_STB = 4'h0;
	localparam logic [3:0] G2_STL = 4'h2;
	localparam logic [3:0] G2_PDB = 4'h4;
	localparam logic [3:0] G2_PDL = 4'h6;
	localparam logic [3:0] G8_STB = 4'h0;
	localparam logic [3:0] G8_STW = 4'h1;
	localparam logic [3:0] G8_LDB = 4'h4;
	localparam logic [3:0] G8_LDW = 4'h5;
	localparam logic [3:0] G0_STB = 4'h4;
	localparam logic [3:0] G0_STW = 4'h5;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	// encoding doubles as the address shift count
	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_WORD = 2'h1,
		SZ_LONG = 2'h2
	} dti_size_type;

	typedef enum logic [2:0] {
		KD_NONE = 3'h0,
		KD_MOVI = 3'h1,
		KD_MOVR = 3'h2,
		KD_LOAD = 3'h3,
		KD_STORE = 3'h4
	} dti_kind_type;

	typedef enum logic [2:0] {
		AM_IND = 3'h0,
		AM_PREDEC = 3'h1,
		AM_POSTINC = 3'h2,
		AM_DISP = 3'h3,
		AM_PC = 3'h4,
		AM_IDX = 3'h5
	} dti_am_type;

	typedef enum logic [2:0] {
		ST_RUN = 3'h1,
		ST_BUSW = 3'h2,
		ST_MEM = 3'h4
	} dti_state_type;

	localparam logic [3:0] BE_BYTE = 4'h1;
	localparam logic [3:0] BE_LOW = 4'h3;
	localparam logic [3:0] BE_HIGH = 4'hc;
	localparam logic [3:0] BE_ALL = 4'hf;

	function automatic logic [31:0] scale_of(dti_size_type s);
		scale_of = 32'h1 << s;
	endfunction : scale_of

	function automatic logic [31:0] sext(logic [31:0] v, dti_size_type s);
		case (s)
			SZ_BYTE: sext = {{24{v[7]}}, v[7:0]};
			SZ_WORD: sext = {{16{v[15]}}, v[15:0]};
			default: sext = v;
		endcase
	endfunction : sext

endpackage : dti_pkg

// ---- hw/dti_dec_if.sv ----
interface dti_dec_if;
	logic [15:0] instr;
	dti_pkg::dti_kind_type kind;
	dti_pkg::dti_am_type am;
	dti_pkg::dti_size_type size;
	logic [3:0] data_idx;
	logic [3:0] base_idx;
	logic [7:0] disp;

	modport dec (
		input instr,
		output kind,
		output am,
		output size,
		output data_idx,
		output base_idx,
		output disp
	);

	modport core (
		output instr,
		input kind,
		input am,
		input size,
		input data_idx,
		input base_idx,
		input disp
	);
endinterface : dti_dec_if

// ---- hw/dti_decode.sv ----
module dti_decode (
	dti_dec_if.dec bus
);

	logic [3:0] op;
	logic [3:0] fn;
	logic [3:0] fm;
	logic [3:0] sub;

	// ----------------------------------------------------------------
	// field extraction
	// ----------------------------------------------------------------
	assign op = bus.instr[dti_pkg::FLD_OP_MSB:dti_pkg::FLD_OP_LSB];
	assign fn = bus.instr[dti_pkg::FLD_N_MSB:dti_pkg::FLD_N_LSB];
	assign fm = bus.instr[dti_pkg::FLD_M_MSB:dti_pkg::FLD_M_LSB];
	assign sub = bus.instr[dti_pkg::FLD_S_MSB:dti_pkg::FLD_S_LSB];

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	always_comb begin
		bus.kind = dti_pkg::KD_NONE;
		bus.am = dti_pkg::AM_IND;
		bus.size = dti_pkg::SZ_LONG;
		bus.data_idx = fn;
		bus.base_idx = fm;
		bus.disp = bus.instr[dti_pkg::FLD_I_MSB:0];
		case (op)
			dti_pkg::OP_MOVI: begin
				bus.kind = dti_pkg::KD_MOVI;
			end
			dti_pkg::OP_LDW_PC: begin
				bus.kind = dti_pkg::KD_LOAD;
				bus.am = dti_pkg::AM_PC;
				bus.size = dti_pkg::SZ_WORD;
			end
			dti_pkg::OP_LDL_PC: begin
				bus.kind = dti_pkg::KD_LOAD;
				bus.am = dti_pkg::AM_PC;
			end
			dti_pkg::OP_GRP6: begin
				// size suffix sits in the low two sub-code bits
				bus.size = dti_pkg::dti_size_type'(sub[1:0]);
				if (sub >= dti_pkg::G6_LDB && sub <= dti_pkg::G6_LDL) begin
					bus.kind = dti_pkg::KD_LOAD;
				end else if (sub == dti_pkg::G6_MOV) begin
					bus.kind = dti_pkg::KD_MOVR;
				end else if (sub >= dti_pkg::G6_PIB && sub <= dti_pkg::G6_PIL) begin
					bus.kind = dti_pkg::KD_LOAD;
					bus.am = dti_pkg::AM_POSTINC;
				end
			end
			dti_pkg::OP_GRP2: begin
				bus.size = dti_pkg::dti_size_type'(sub[1:0]);
				bus.data_idx = fm;
				bus.base_idx = fn;
				if (sub >= dti_pkg::G2_STB && sub <= dti_pkg::G2_STL) begin
					bus.kind = dti_pkg::KD_STORE;
				end else if (sub >= dti_pkg::G2_PDB && sub <= dti_pkg::G2_PDL) begin
					bus.kind = dti_pkg::KD_STORE;
					bus.am = dti_pkg::AM_PREDEC;
				end
			end
			dti_pkg::OP_STL_D: begin
				bus.kind = dti_pkg::KD_STORE;
				bus.am = dti_pkg::AM_DISP;
				bus.data_idx = fm;
				bus.base_idx = fn;
				bus.disp = {4'h0, sub};
			end
			dti_pkg::OP_LDL_D: begin
				bus.kind = dti_pkg::KD_LOAD;
				bus.am = dti_pkg::AM_DISP;
				bus.disp = {4'h0, sub};
			end
			dti_pkg::OP_GRP8: begin
				bus.am = dti_pkg::AM_DISP;
				bus.disp = {4'h0, sub};
				bus.base_idx = fm;
				bus.data_idx = dti_pkg::REG_ZERO;
				bus.size = fn[0] ? dti_pkg::SZ_WORD : dti_pkg::SZ_BYTE;
				if (fn == dti_pkg::G8_STB || fn == dti_pkg::G8_STW) begin
					bus.kind = dti_pkg::KD_STORE;
				end else if (fn == dti_pkg::G8_LDB || fn == dti_pkg::G8_LDW) begin
					bus.kind = dti_pkg::KD_LOAD;
				end
			end
			dti_pkg::OP_GRP0: begin
				bus.am = dti_pkg::AM_IDX;
				bus.size = dti_pkg::dti_size_type'(sub[1:0]);
				bus.data_idx = fm;
				bus.base_idx = fn;
				if (sub == dti_pkg::G0_STB || sub == dti_pkg::G0_STW) begin
					bus.kind = dti_pkg::KD_STORE;
				end
			end
			default: begin
				bus.kind = dti_pkg::KD_NONE;
			end
		endcase
	end

endmodule : dti_decode

// ---- hw/dti_core.sv ----
module dti_core (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic instr_valid,
	input wire logic [15:0] instr,
	input wire logic [31:0] instr_pc,
	output logic instr_ready_q,
	output logic illegal_q,
	input wire logic fetch_busy,
	output logic mem_req_q,
	output logic mem_we_q,
	output logic [31:0] mem_addr_q,
	output logic [31:0] mem_wdata_q,
	output logic [3:0] mem_be_q,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	input wire logic status_load,
	input wire logic [31:0] status_wdata,
	output logic [31:0] status_word_q,
	input wire logic [3:0] dbg_idx,
	output logic [31:0] dbg_data_q
);

	dti_dec_if dec_bus ();
	dti_decode u_dec (
		.bus(dec_bus)
	);
	assign dec_bus.instr = instr;

	logic [31:0] regs [dti_pkg::REG_CNT];
	dti_pkg::dti_state_type state_q;
	logic accept;
	logic is_mem;
	logic [31:0] base_v;
	logic [31:0] data_v;
	logic [31:0] scale;
	logic [31:0] disp_sc;
	logic [31:0] addr_d;
	logic [3:0] be_d;
	logic [31:0] wdata_d;
	logic ld_q;
	logic [3:0] ld_dst_q;
	dti_pkg::dti_size_type size_q;
	logic post_q;
	logic [3:0] post_idx_q;
	logic [31:0] post_val_q;
	logic [31:0] lane_v;
	logic [31:0] load_val;
	logic done;

	// ----------------------------------------------------------------
	// address formation
	// ----------------------------------------------------------------
	// no privilege input: the group is legal in every state
	assign accept = state_q == dti_pkg::ST_RUN && instr_valid && instr_ready_q;
	assign is_mem = dec_bus.kind == dti_pkg::KD_LOAD
		|| dec_bus.kind == dti_pkg::KD_STORE;
	assign base_v = regs[dec_bus.base_idx];
	assign data_v = regs[dec_bus.data_idx];
	assign scale = dti_pkg::scale_of(dec_bus.size);
	assign disp_sc = {24'h0, dec_bus.disp} << dec_bus.size;

	always_comb begin
		case (dec_bus.am)
			dti_pkg::AM_PC: addr_d = instr_pc + disp_sc;
			dti_pkg::AM_DISP: addr_d = base_v + disp_sc;
			dti_pkg::AM_PREDEC: addr_d = base_v - scale;
			dti_pkg::AM_IDX: addr_d = base_v + regs[dti_pkg::REG_ZERO];
			default: addr_d = base_v;
		endcase
	end

	// ----------------------------------------------------------------
	// store lanes
	// ----------------------------------------------------------------
	// little-endian lanes; data is replicated so any lane sees its byte
	always_comb begin
		case (dec_bus.size)
			dti_pkg::SZ_BYTE: begin
				be_d = dti_pkg::BE_BYTE << addr_d[1:0];
				wdata_d = {4{data_v[7:0]}};
			end
			dti_pkg::SZ_WORD: begin
				be_d = addr_d[1] ? dti_pkg::BE_HIGH : dti_pkg::BE_LOW;
				wdata_d = {2{data_v[15:0]}};
			end
			default: begin
				be_d = dti_pkg::BE_ALL;
				wdata_d = data_v;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// load extraction
	// ----------------------------------------------------------------
	assign lane_v = size_q == dti_pkg::SZ_LONG ? mem_rdata : mem_rdata
		>> {mem_addr_q[1], mem_addr_q[0] && size_q == dti_pkg::SZ_BYTE, 3'h0};
	assign load_val = dti_pkg::sext(lane_v, size_q);
	assign done = state_q == dti_pkg::ST_MEM && mem_ack;

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_q <= dti_pkg::ST_RUN;
			instr_ready_q <= 1'b0;
			mem_req_q <= 1'b0;
		end else begin
			case (state_q)
				dti_pkg::ST_RUN: begin
					instr_ready_q <= 1'b1;
					if (accept && is_mem) begin
						instr_ready_q <= 1'b0;
						if (fetch_busy) begin
							state_q <= dti_pkg::ST_BUSW;
						end else begin
							state_q <= dti_pkg::ST_MEM;
							mem_req_q <= 1'b1;
						end
					end
				end
				dti_pkg::ST_BUSW: begin
					if (!fetch_busy) begin
						state_q <= dti_pkg::ST_MEM;
						mem_req_q <= 1'b1;
					end
				end
				dti_pkg::ST_MEM: begin
					if (mem_ack) begin
						// ready only after the load result is in place
						state_q <= dti_pkg::ST_RUN;
						mem_req_q <= 1'b0;
						instr_ready_q <= 1'b1;
					end
				end
				default: begin
					state_q <= dti_pkg::ST_RUN;
					mem_req_q <= 1'b0;
					instr_ready_q <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// access capture
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mem_we_q <= 1'b0;
			mem_addr_q <= dti_pkg::REG_RESET;
			mem_wdata_q <= dti_pkg::REG_RESET;
			mem_be_q <= 4'h0;
			ld_q <= 1'b0;
			ld_dst_q <= dti_pkg::REG_ZERO;
			size_q <= dti_pkg::SZ_LONG;
			post_q <= 1'b0;
			post_idx_q <= dti_pkg::REG_ZERO;
			post_val_q <= dti_pkg::REG_RESET;
		end else if (accept && is_mem) begin
			mem_we_q <= dec_bus.kind == dti_pkg::KD_STORE;
			mem_addr_q <= addr_d;
			mem_wdata_q <= wdata_d;
			mem_be_q <= be_d;
			ld_q <= dec_bus.kind == dti_pkg::KD_LOAD;
			ld_dst_q <= dec_bus.data_idx;
			size_q <= dec_bus.size;
			post_q <= dec_bus.am == dti_pkg::AM_POSTINC;
			post_idx_q <= dec_bus.base_idx;
			post_val_q <= base_v + scale;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			illegal_q <= 1'b0;
		end else begin
			illegal_q <= accept && dec_bus.kind == dti_pkg::KD_NONE;
		end
	end
	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	// later writes win: a post-increment load into its own base keeps data
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < dti_pkg::REG_CNT; i++) begin
				regs[i] <= dti_pkg::REG_RESET;
			end
		end else begin
			if (accept && dec_bus.kind == dti_pkg::KD_MOVI) begin
				regs[dec_bus.data_idx] <= dti_pkg::sext({24'h0, dec_bus.disp},
					dti_pkg::SZ_BYTE);
			end
			if (accept && dec_bus.kind == dti_pkg::KD_MOVR) begin
				regs[dec_bus.data_idx] <= base_v;
			end
			if (accept && dec_bus.am == dti_pkg::AM_PREDEC
				&& dec_bus.kind == dti_pkg::KD_STORE) begin
				regs[dec_bus.base_idx] <= addr_d;
			end
			if (done && post_q) begin
				regs[post_idx_q] <= post_val_q;
			end
			if (done && ld_q) begin
				regs[ld_dst_q] <= load_val;
			end
		end
	end

	// ----------------------------------------------------------------
	// status word and debug read
	// ----------------------------------------------------------------
	// only the external load port writes it; transfers leave it alone
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			status_word_q <= dti_pkg::STATUS_RESET;
		end else if (status_load) begin
			status_word_q <= status_wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			dbg_data_q <= dti_pkg::REG_RESET;
		end else begin
			dbg_data_q <= regs[dbg_idx];
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_status_hold;
		@(posedge clk_sys) disable iff (!rstn)
		accept && !status_load |=> $stable(status_word_q);
	endproperty
	a_status_hold: assert property (p_status_hold)
		else $error("status word changed by a transfer");

	property p_reg_single;
		@(posedge clk_sys) disable iff (!rstn)
		accept && (dec_bus.kind == dti_pkg::KD_MOVI
			|| dec_bus.kind == dti_pkg::KD_MOVR) |=> instr_ready_q;
	endproperty
	a_reg_single: assert property (p_reg_single)
		else $error("register move took more than one cycle");

	property p_load_use;
		@(posedge clk_sys) disable iff (!rstn)
		done && ld_q |=> instr_ready_q
			&& regs[$past(ld_dst_q)] == $past(load_val);
	endproperty
	a_load_use: assert property (p_load_use)
		else $error("ready before load result written");

	property p_mem_stall;
		@(posedge clk_sys) disable iff (!rstn)
		state_q != dti_pkg::ST_RUN |-> !instr_ready_q;
	endproperty
	a_mem_stall: assert property (p_mem_stall)
		else $error("instruction taken during access");

	property p_fetch_wait;
		@(posedge clk_sys) disable iff (!rstn)
		accept && is_mem && fetch_busy |=> !mem_req_q
			&& state_q == dti_pkg::ST_BUSW;
	endproperty
	a_fetch_wait: assert property (p_fetch_wait)
		else $error("data access issued over a busy fetch");

	property p_movi;
		@(posedge clk_sys) disable iff (!rstn)
		accept && dec_bus.kind == dti_pkg::KD_MOVI |=>
			regs[$past(dec_bus.data_idx)]
			== {{24{$past(instr[7])}}, $past(instr[7:0])};
	endproperty
	a_movi: assert property (p_movi)
		else $error("immediate move result wrong");

	property p_predec;
		@(posedge clk_sys) disable iff (!rstn)
		accept && dec_bus.am == dti_pkg::AM_PREDEC |=>
			mem_addr_q == $past(base_v) - $past(scale)
			&& regs[$past(dec_bus.base_idx)] == mem_addr_q;
	endproperty
	a_predec: assert property (p_predec)
		else $error("pre-decrement address wrong");

	property p_disp_long;
		@(posedge clk_sys) disable iff (!rstn)
		accept && dec_bus.am == dti_pkg::AM_DISP
			&& dec_bus.size == dti_pkg::SZ_LONG |=>
			mem_addr_q == $past(base_v) + {$past(dec_bus.disp), 2'h0};
	endproperty
	a_disp_long: assert property (p_disp_long)
		else $error("longword displacement not quadrupled");

	property p_pc_word;
		@(posedge clk_sys) disable iff (!rstn)
		accept && dec_bus.am == dti_pkg::AM_PC
			&& dec_bus.size == dti_pkg::SZ_WORD |=>
			mem_addr_q == $past(instr_pc) + {$past(dec_bus.disp), 1'b0};
	endproperty
	a_pc_word: assert property (p_pc_word)
		else $error("pc-relative word address wrong");

	property p_byte_lane;
		@(posedge clk_sys) disable iff (!rstn)
		mem_req_q && mem_we_q && size_q == dti_pkg::SZ_BYTE
			|-> $onehot(mem_be_q);
	endproperty
	a_byte_lane: assert property (p_byte_lane)
		else $error("byte store enables more than one lane");

endmodule : dti_core

// ---- dv/dti_mem_model.sv ----
module dti_mem_model (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic [3:0] mem_be,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [64];
	logic [7:0] lf_q;
	logic [1:0] wait_q;

	initial begin
		for (int i = 0; i < 64; i++)
			mem[i] = {4{i[7:0]}} ^ 32'h5a3c_9671;
	end

	// ----
	// data memory: 256 bytes, random 0..3 wait cycles
	// ----
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mem_ack <= 1'b0;
			mem_rdata <= 32'h0;
			lf_q <= 8'h5b;
			wait_q <= 2'h0;
		end else begin
			mem_ack <= 1'b0;
			// stale read data must not look valid
			mem_rdata <= ~mem_rdata;
			lf_q <= {lf_q[6:0], lf_q[7] ^ lf_q[5] ^ lf_q[4] ^ lf_q[3]};
			if (mem_req && !mem_ack) begin
				if (wait_q != 2'h0) begin
					wait_q <= wait_q - 2'h1;
				end else begin
					mem_ack <= 1'b1;
					wait_q <= lf_q[1:0];
					if (!mem_we)
						mem_rdata <= mem[mem_addr[7:2]];
					for (int b = 0; b < 4; b++)
						if (mem_we && mem_be[b])
							mem[mem_addr[7:2]][8*b +: 8] <= mem_wdata[8*b +: 8];
				end
			end
		end
	end
endmodule : dti_mem_model

// ---- dv/tb_top.sv ----
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, rstn, instr_valid, fetch_busy, status_load;
	logic [15:0] instr;
	logic [31:0] instr_pc, status_wdata, mem_rdata, dbg_data_q;
	logic [31:0] mem_addr_q, mem_wdata_q, status_word_q;
	logic [3:0] dbg_idx, mem_be_q;
	logic instr_ready_q, illegal_q, mem_req_q, mem_we_q, mem_ack;
	int err_count, total_checks, last_k;
	logic [31:0] sregs [16];
	logic [31:0] smem [64];
	logic [31:0] rnd, stat, tprev;
	logic [31:0] bz = 32'h8efa;
	logic b_s, r_s;
	logic [15:0] tmpl [25] = '{16'he000, 16'h9000, 16'hd000, 16'h6000,
		16'h6001, 16'h6002, 16'h6003, 16'h6004, 16'h6005, 16'h6006,
		16'h2000, 16'h2001, 16'h2002, 16'h2004, 16'h2005, 16'h2006,
		16'h1000, 16'h5000, 16'h8000, 16'h8100, 16'h8400, 16'h8500,
		16'h0004, 16'h0005, 16'h0009};

	dti_core i_dut (.clk_sys(clk_sys), .rstn(rstn),
		.instr_valid(instr_valid), .instr(instr), .instr_pc(instr_pc),
		.instr_ready_q(instr_ready_q), .illegal_q(illegal_q),
		.fetch_busy(fetch_busy), .mem_req_q(mem_req_q),
		.mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q),
		.mem_wdata_q(mem_wdata_q), .mem_be_q(mem_be_q),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.status_load(status_load), .status_wdata(status_wdata),
		.status_word_q(status_word_q), .dbg_idx(dbg_idx),
		.dbg_data_q(dbg_data_q));
	dti_mem_model i_mem (.clk_sys(clk_sys), .rstn(rstn),
		.mem_req(mem_req_q), .mem_we(mem_we_q), .mem_addr(mem_addr_q),
		.mem_wdata(mem_wdata_q), .mem_be(mem_be_q), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata));

	always #2.5 clk_sys = ~clk_sys;

	// ----
	// helpers and reference model
	// ----
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic logic [31:0] rd(logic [31:0] a, logic [1:0] z);
		logic [31:0] w;
		w = smem[a[7:2]];
		if (z == 2'h0)
			return {{24{w[8*a[1:0]+7]}}, w[8*a[1:0] +: 8]};
		if (z == 2'h1)
			return {{16{w[16*a[1]+15]}}, w[16*a[1] +: 16]};
		return w;
	endfunction : rd

	task automatic wr(logic [31:0] a, logic [1:0] z, logic [31:0] v);
		if (z == 2'h0)
			smem[a[7:2]][8*a[1:0] +: 8] = v[7:0];
		else if (z == 2'h1)
			smem[a[7:2]][16*a[1] +: 16] = v[15:0];
		else
			smem[a[7:2]] = v;
	endtask : wr

	// last_k: 0 register op, 1 memory op, 2 not in this group
	task automatic ref_exec(logic [15:0] w, logic [31:0] pc);
		logic [3:0] n, m, d;
		logic [1:0] z;
		logic [31:0] a;
		n = w[11:8];
		m = w[7:4];
		d = w[3:0];
		z = d[1:0];
		last_k = 1;
		case (w[15:12])
			4'he: begin
				sregs[n] = {{24{w[7]}}, w[7:0]};
				last_k = 0;
			end
			4'h9: sregs[n] = rd(pc + {w[7:0], 1'b0}, 2'h1);
			4'hd: sregs[n] = rd(pc + {w[7:0], 2'h0}, 2'h2);
			4'h6: if (d == 4'h3) begin
				sregs[n] = sregs[m];
				last_k = 0;
			end else if (d < 4'h7) begin
				a = sregs[m];
				if (d[2])
					sregs[m] = a + (32'h1 << z);
				sregs[n] = rd(a, z);
			end else
				last_k = 2;
			4'h2: if (d < 4'h7 && d != 4'h3) begin
				if (d[2])
					sregs[n] = sregs[n] - (32'h1 << z);
				wr(sregs[n], z, sregs[m]);
			end else
				last_k = 2;
			4'h1: wr(sregs[n] + {d, 2'h0}, 2'h2, sregs[m]);
			4'h5: sregs[n] = rd(sregs[m] + {d, 2'h0}, 2'h2);
			4'h8: begin
				a = sregs[m] + ({28'h0, d} << n[0]);
				if (n == 4'h0 || n == 4'h1)
					wr(a, {1'b0, n[0]}, sregs[0]);
				else if (n == 4'h4 || n == 4'h5)
					sregs[0] = rd(a, {1'b0, n[0]});
				else
					last_k = 2;
			end
			4'h0: if (d == 4'h4 || d == 4'h5)
				wr(sregs[0] + sregs[n], {1'b0, d[0]}, sregs[m]);
			else
				last_k = 2;
			default: last_k = 2;
		endcase
	endtask : ref_exec

	function automatic logic [15:0] gen(logic [31:0] r);
		logic [15:0] t, w;
		t = tmpl[r[31:27] % 25];
		case (t[15:12])
			4'h8: w = t | (r[15:0] & 16'h00ff);
			4'h6, 4'h2, 4'h0: w = t | (r[15:0] & 16'h0ff0);
			default: w = t | (r[15:0] & 16'h0fff);
		endcase
		// same base and data on pre-decrement left out
		if (t[15:12] == 4'h2 && t[2] && w[11:8] == w[7:4])
			w[4] = ~w[4];
		return w;
	endfunction : gen

	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	// returns at the edge that takes the word, valid still high
	task automatic issue(logic [15:0] w, logic [31:0] pc);
		int n;
		instr_valid <= 1'b1;
		instr <= w;
		instr_pc <= pc;
		n = 0;
		@(negedge clk_sys);
		while (instr_ready_q !== 1'b1 && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
		check("take", instr_ready_q, 32'h1);
		@(posedge clk_sys);
		ref_exec(w, pc);
	endtask : issue

	task automatic settle();
		int n;
		instr_valid <= 1'b0;
		@(negedge clk_sys);
		check("illegal", illegal_q, last_k == 2);
		if (last_k == 1)
			check("ready", instr_ready_q, 32'h0);
		n = 0;
		while (instr_ready_q !== 1'b1 && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
		check("resume", instr_ready_q, 32'h1);
		@(posedge clk_sys);
	endtask : settle

	task automatic check_reg(int i);
		dbg_idx <= i[3:0];
		@(posedge clk_sys);
		@(negedge clk_sys);
		check("reg", dbg_data_q, sregs[i]);
		@(posedge clk_sys);
	endtask : check_reg

	// ----
	// fetch contention and its monitor
	// ----
	always @(posedge clk_sys) begin
		bz = lfsr(bz);
		fetch_busy <= bz[2] & bz[0];
	end

	always @(posedge clk_sys) begin
		b_s = fetch_busy;
		r_s = mem_req_q;
		@(negedge clk_sys);
		if (rstn && !r_s && mem_req_q)
			check("busy", b_s, 32'h0);
	end

	initial begin
		#400us;
		err_count++;
		tally_and_finish();
	end

	initial begin
		clk_sys = 1'b0;
		rstn = 1'b0;
		{instr_valid, status_load} = 2'h0;
		{instr, instr_pc, status_wdata, dbg_idx} = '0;
		rnd = 32'h8efa;
		for (int i = 0; i < 64; i++)
			smem[i] = {4{i[7:0]}} ^ 32'h5a3c_9671;
		for (int i = 0; i < 16; i++)
			sregs[i] = 32'h0;
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		stat = lfsr(rnd);
		status_load <= 1'b1;
		status_wdata <= stat;
		@(posedge clk_sys);
		status_load <= 1'b0;
		// back-to-back immediates into every register
		for (int i = 0; i < 16; i++) begin
			issue(16'he000 | (i << 8) | ((i * 16'h11) ^ 16'h80), 32'h0);
			if (i > 0)
				check("gap", 32'($time) - tprev, 32'h5);
			tprev = 32'($time);
		end
		settle();
		for (int i = 0; i < 16; i++)
			check_reg(i);
		repeat (300) begin
			rnd = lfsr(rnd);
			issue(gen(rnd), lfsr(rnd));
			settle();
			for (int i = 0; i < 16; i++)
				check_reg(i);
		end
		// read back every word: stores must leave other lanes alone
		issue(16'he100, 32'h0);
		settle();
		repeat (64) begin
			issue(16'h6216, 32'h0);
			settle();
			check_reg(2);
		end
		check("status", status_word_q, stat);
		tally_and_finish();
	end
endmodule : tb_top
